// ### rtl/uie_irq_enable.sv
// interrupt enable register set of the bus controller, with sticky event status
// assumes event pulses come from logic on clk; software on AXI4-Lite
//
// The AXI4-Lite slave port was left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module uie_irq_enable (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // write address channel
  input  wire logic [11:0]             awaddr,
  input  wire logic                    awvalid,
  output var  logic                    awready,
  // write data channel
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output var  logic                    wready,
  // write response channel
  output var  logic [1:0]              bresp,
  output var  logic                    bvalid,
  input  wire logic                    bready,
  // read address channel
  input  wire logic [11:0]             araddr,
  input  wire logic                    arvalid,
  output var  logic                    arready,
  // read data channel
  output var  logic [31:0]             rdata,
  output var  logic [1:0]              rresp,
  output var  logic                    rvalid,
  input  wire logic                    rready,
  // controller events and enables
  input  wire uie_pkg::uie_events_t    eventPulse,
  output var  uie_pkg::uie_events_t    eventEnable,
  // interrupt
  output var  logic                    irq
);
  import uie_pkg::*;

  // ==========================================================================
  // state
  logic        awFull;
  logic        wFull;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic [24:0] status;

  logic        next_awFull;
  logic        next_wFull;
  logic [11:0] next_wrAddr;
  logic [31:0] next_wrData;
  logic [3:0]  next_wrStrb;
  logic        next_awready;
  logic        next_wready;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic        next_arready;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  uie_events_t next_enable;
  logic [24:0] next_status;
  logic        next_irq;

  // ==========================================================================
  // write decode
  logic        wrFire;
  logic [11:0] wrWord;
  logic [11:0] rdWord;
  logic [31:0] wMask;
  logic [31:0] wBits;
  logic [24:0] enableBits;
  logic [24:0] eventBits;
  uie_events_t setBits;
  logic        wrMapped;

  // strobes gate each byte lane
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wMask[8*b +: 8] = {8{wrStrb[b]}};
  end

  assign wrFire     = awFull && wFull && !bvalid;
  assign wrWord     = {wrAddr[11:2], 2'h0};
  assign rdWord     = {araddr[11:2], 2'h0};
  assign wBits      = wrData & wMask;
  assign enableBits = eventEnable;
  assign eventBits  = eventPulse;
  assign setBits    = uie_events_t'(wBits[24:0]);
  assign wrMapped   = (wrWord == UIE_OFS_ENABLE) || (wrWord == UIE_OFS_SET) ||
                      (wrWord == UIE_OFS_CLEAR)  || (wrWord == UIE_OFS_STATUS);

  // ==========================================================================
  // write channels: address and data taken in either order
  always_comb begin
    next_awFull = awFull;
    next_wFull  = wFull;
    next_wrAddr = wrAddr;
    next_wrData = wrData;
    next_wrStrb = wrStrb;
    next_bvalid = bvalid;
    next_bresp  = bresp;
    if (awvalid && awready) begin
      next_awFull = 1'b1;
      next_wrAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_wFull  = 1'b1;
      next_wrData = wdata;
      next_wrStrb = wstrb;
    end
    if (wrFire) begin
      next_awFull = 1'b0;
      next_wFull  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wrMapped ? UIE_RESP_OKAY : UIE_RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // one write in flight; ready drops until the response is taken
    next_awready = !next_awFull && !next_bvalid;
    next_wready  = !next_wFull && !next_bvalid;
  end

  // ==========================================================================
  // enable state shared by the three enable views
  always_comb begin
    next_enable = eventEnable;
    if (wrFire) begin
      case (wrWord)
        UIE_OFS_ENABLE: begin
          // unstrobed lanes keep their value
          next_enable = uie_events_t'((enableBits & ~wMask[24:0]) |
                                      wBits[24:0]);
        end
        UIE_OFS_SET: begin
          // ones set, zeros leave alone
          next_enable.busResetEvent = eventEnable.busResetEvent |
                                      setBits.busResetEvent;
          next_enable.transferStarted = eventEnable.transferStarted |
                                        setBits.transferStarted;
          next_enable.inEndpointTransferEnd = eventEnable.inEndpointTransferEnd |
                                              setBits.inEndpointTransferEnd;
          next_enable.controlDataStageDone = eventEnable.controlDataStageDone |
                                             setBits.controlDataStageDone;
          next_enable.isoInTransferEnd = eventEnable.isoInTransferEnd |
                                         setBits.isoInTransferEnd;
          next_enable.outEndpointTransferEnd = eventEnable.outEndpointTransferEnd |
                                               setBits.outEndpointTransferEnd;
          next_enable.isoOutTransferEnd = eventEnable.isoOutTransferEnd |
                                          setBits.isoOutTransferEnd;
          next_enable.startOfFrame = eventEnable.startOfFrame |
                                     setBits.startOfFrame;
          next_enable.generalBusStatusEvent = eventEnable.generalBusStatusEvent |
                                              setBits.generalBusStatusEvent;
          next_enable.controlSetupReceived = eventEnable.controlSetupReceived |
                                             setBits.controlSetupReceived;
          next_enable.endpointDataEvent = eventEnable.endpointDataEvent |
                                          setBits.endpointDataEvent;
        end
        UIE_OFS_CLEAR: begin
          next_enable = uie_events_t'(enableBits & ~wBits[24:0]);
        end
        default: begin
          next_enable = eventEnable;
        end
      endcase
    end
  end

  // ==========================================================================
  // sticky status; a new event wins over a clear in the same cycle
  always_comb begin
    next_status = status;
    if (wrFire && (wrWord == UIE_OFS_STATUS)) begin
      next_status = status & ~wBits[24:0];
    end
    next_status = next_status | eventBits;
    // next values used so irq is not a cycle behind the status
    next_irq = |(next_status & next_enable);
  end

  // ==========================================================================
  // read channel
  always_comb begin
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      case (rdWord)
        UIE_OFS_ENABLE, UIE_OFS_SET, UIE_OFS_CLEAR: begin
          next_rdata = {7'h00, enableBits};
          next_rresp = UIE_RESP_OKAY;
        end
        UIE_OFS_STATUS: begin
          next_rdata = {7'h00, status};
          next_rresp = UIE_RESP_OKAY;
        end
        default: begin
          next_rdata = 32'h0;
          next_rresp = UIE_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awFull      <= 1'b0;
      wFull       <= 1'b0;
      wrAddr      <= 12'h0;
      wrData      <= 32'h0;
      wrStrb      <= 4'h0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= UIE_RESP_OKAY;
      arready     <= 1'b0;
      rvalid      <= 1'b0;
      rdata       <= 32'h0;
      rresp       <= UIE_RESP_OKAY;
      eventEnable <= uie_events_t'(UIE_ENABLE_RESET);
      status      <= UIE_STATUS_RESET;
      irq         <= 1'b0;
    end else begin
      awFull      <= next_awFull;
      wFull       <= next_wFull;
      wrAddr      <= next_wrAddr;
      wrData      <= next_wrData;
      wrStrb      <= next_wrStrb;
      awready     <= next_awready;
      wready      <= next_wready;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      arready     <= next_arready;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      rresp       <= next_rresp;
      eventEnable <= next_enable;
      status      <= next_status;
      irq         <= next_irq;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_set_bus_reset;
    wrFire && (wrWord == UIE_OFS_SET) && wBits[UIE_BIT_BUS_RESET]
      |=> eventEnable.busResetEvent && bvalid && (bresp == UIE_RESP_OKAY);
  endproperty
  a_set_bus_reset: assert property (p_set_bus_reset)
    else $error("bus reset enable not set by write");

  property p_set_started;
    wrFire && (wrWord == UIE_OFS_SET) && wBits[UIE_BIT_STARTED]
      |=> eventEnable.transferStarted;
  endproperty
  a_set_started: assert property (p_set_started)
    else $error("started enable not set by write");

  property p_set_in_end;
    wrFire && (wrWord == UIE_OFS_SET)
      |=> ((enableBits[9:2] & $past(wBits[9:2])) == $past(wBits[9:2]));
  endproperty
  a_set_in_end: assert property (p_set_in_end)
    else $error("IN endpoint enable not set by write");

  property p_set_out_end;
    wrFire && (wrWord == UIE_OFS_SET)
      |=> ((enableBits[19:12] & $past(wBits[19:12])) == $past(wBits[19:12]));
  endproperty
  a_set_out_end: assert property (p_set_out_end)
    else $error("OUT endpoint enable not set by write");

  property p_set_ctrl_data;
    wrFire && (wrWord == UIE_OFS_SET) && setBits.controlDataStageDone
      |=> eventEnable.controlDataStageDone;
  endproperty
  a_set_ctrl_data: assert property (p_set_ctrl_data)
    else $error("control data done enable not set by write");

  property p_set_iso_in;
    wrFire && (wrWord == UIE_OFS_SET) && setBits.isoInTransferEnd
      |=> eventEnable.isoInTransferEnd;
  endproperty
  a_set_iso_in: assert property (p_set_iso_in)
    else $error("isochronous IN enable not set by write");

  property p_set_iso_out;
    wrFire && (wrWord == UIE_OFS_SET) && setBits.isoOutTransferEnd
      |=> eventEnable.isoOutTransferEnd;
  endproperty
  a_set_iso_out: assert property (p_set_iso_out)
    else $error("isochronous OUT enable not set by write");

  property p_read_live;
    arvalid && arready && ((rdWord == UIE_OFS_SET) || (rdWord == UIE_OFS_CLEAR))
      |=> rvalid && (rdata == {7'h00, $past(enableBits)}) && (rresp == UIE_RESP_OKAY);
  endproperty
  a_read_live: assert property (p_read_live)
    else $error("enable read back wrong");

  property p_zero_keeps;
    wrFire && (wrWord == UIE_OFS_SET)
      |=> ((enableBits & ~$past(wBits[24:0])) == ($past(enableBits) & ~$past(wBits[24:0])));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero written to set register changed an enable");

  property p_clear;
    wrFire && (wrWord == UIE_OFS_CLEAR)
      |=> (enableBits == ($past(enableBits) & ~$past(wBits[24:0])));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear register did not clear enables");

  property p_plain_write;
    wrFire && (wrWord == UIE_OFS_ENABLE)
      |=> (enableBits == (($past(enableBits) & ~$past(wMask[24:0])) | $past(wBits[24:0])));
  endproperty
  a_plain_write: assert property (p_plain_write)
    else $error("plain enable write wrong");

  property p_event_sticky;
    (eventBits != 25'h0) |=> ((status & $past(eventBits)) == $past(eventBits)) [*1] ##1 1'b1;
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("event lost from status");

  property p_irq_follows;
    (|(eventBits & enableBits)) && !wrFire |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("unmasked event did not raise irq");

  property p_read_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data changed before taken");

  c_set_write:   cover property (wrFire && (wrWord == UIE_OFS_SET));
  c_clear_write: cover property (wrFire && (wrWord == UIE_OFS_CLEAR));
  c_read_set:    cover property (arvalid && arready && (rdWord == UIE_OFS_SET));
  c_irq_rise:    cover property ($rose(irq));

endmodule

`default_nettype wire

// ### rtl/uie_pkg.sv
// constants, field layout and carrier types of the interrupt enable block
// assumes a 32-bit AXI4-Lite register bus and a single synchronous clock domain
//
// Function
// - writing one to bit 0 of the set register enables the bus reset interrupt
// - writing one to bit 1 of the set register enables the transfer started interrupt
// - set bits 2..9 enable IN endpoint 0..7 transfer end interrupts
// - set bit 10 enables the control data stage done interrupt
// - set bit 11 enables the isochronous IN transfer end interrupt
// - set bits 12..19 enable OUT endpoint 0..7 transfer end interrupts
// - set bit 20 enables the isochronous OUT transfer end interrupt
// - set bit 21 enables the start of frame interrupt
// - set bit 22 enables the general bus status interrupt
// - set bit 23 enables the control setup received interrupt
// - set bit 24 enables the endpoint data interrupt
// - clear register writes of one disable the same enables, reads show shared state
// - plain read-write enable register shares state with set and clear registers

package uie_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          UIE_ADDR_W     = 12;
  localparam int          UIE_DATA_W     = 32;
  localparam int          UIE_NUM_EVENTS = 25;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] UIE_OFS_ENABLE = 12'h300;
  localparam logic [11:0] UIE_OFS_SET    = 12'h304;
  localparam logic [11:0] UIE_OFS_CLEAR  = 12'h308;
  localparam logic [11:0] UIE_OFS_STATUS = 12'h30c;

  // ==========================================================================
  // field positions
  localparam int          UIE_BIT_BUS_RESET = 0;
  localparam int          UIE_BIT_STARTED   = 1;
  localparam int          UIE_BIT_IN_LO     = 2;
  localparam int          UIE_BIT_IN_HI     = 9;
  localparam int          UIE_BIT_OUT_LO    = 12;
  localparam int          UIE_BIT_OUT_HI    = 19;

  // ==========================================================================
  // reset values and responses
  localparam logic [24:0] UIE_ENABLE_RESET = 25'h0;
  localparam logic [24:0] UIE_STATUS_RESET = 25'h0;
  localparam logic [1:0]  UIE_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  UIE_RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // one bit per controller event, bit 24 first
  typedef struct packed {
    logic       endpointDataEvent;
    logic       controlSetupReceived;
    logic       generalBusStatusEvent;
    logic       startOfFrame;
    logic       isoOutTransferEnd;
    logic [7:0] outEndpointTransferEnd;
    logic       isoInTransferEnd;
    logic       controlDataStageDone;
    logic [7:0] inEndpointTransferEnd;
    logic       transferStarted;
    logic       busResetEvent;
  } uie_events_t;

endpackage

// ### sim/uie_irq_enable_bench.sv
// self-checking bench for the interrupt enable register set
// assumes the design answers on AXI4-Lite and takes event pulses on clk

`timescale 1ns/1ps
`default_nettype none

module uie_irq_enable_bench;
  import uie_pkg::*;

  // ==========================================================================
  // signals
  logic              clk;
  logic              nrst;
  logic [11:0]       awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [11:0]       araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  uie_events_t       eventPulse;
  uie_events_t       eventEnable;
  logic              irq;
  int                failCount;
  int                checks;
  int                cycles;
  logic [31:0]       acc;

  uie_irq_enable dut_u (
    .clk(clk), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .eventPulse(eventPulse), .eventEnable(eventEnable), .irq(irq)
  );

  // ==========================================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the whole run takes well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount = failCount + 1;
      final_report();
    end
  end

  // ==========================================================================
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failCount = failCount + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // bus cycles: payload held until each channel's own ready edge
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic bus_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // enable lines settle at the apply edge, so look a moment later
  task automatic check_lines(input logic [31:0] exp, input logic expIrq);
    #1;
    check({7'h0, eventEnable}, exp);
    check({31'h0, irq}, {31'h0, expIrq});
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    awaddr = 12'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    eventPulse = '0;
    failCount = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    // reset state on all three enable views
    bus_read(UIE_OFS_ENABLE, 32'h0, UIE_RESP_OKAY);
    bus_read(UIE_OFS_SET, 32'h0, UIE_RESP_OKAY);
    bus_read(UIE_OFS_CLEAR, 32'h0, UIE_RESP_OKAY);
    check_lines(32'h0, 1'b0);
    // one bit at a time, zeros elsewhere must keep earlier enables
    acc = 32'h0;
    for (int i = 0; i < 25; i++) begin
      bus_write(UIE_OFS_SET, 32'h1 << i, UIE_RESP_OKAY);
      acc = acc | (32'h1 << i);
      check_lines(acc, 1'b0);
      bus_read(UIE_OFS_SET, acc, UIE_RESP_OKAY);
    end
    // unused upper bits read zero
    bus_write(UIE_OFS_SET, 32'hffffffff, UIE_RESP_OKAY);
    bus_read(UIE_OFS_SET, 32'h01ffffff, UIE_RESP_OKAY);
    // clear register works on the shared state
    bus_write(UIE_OFS_CLEAR, 32'h01000820, UIE_RESP_OKAY);
    bus_read(UIE_OFS_ENABLE, 32'h00fff7df, UIE_RESP_OKAY);
    bus_read(UIE_OFS_CLEAR, 32'h00fff7df, UIE_RESP_OKAY);
    // plain register writes both ways, set view follows
    bus_write(UIE_OFS_ENABLE, 32'h00100001, UIE_RESP_OKAY);
    bus_read(UIE_OFS_SET, 32'h00100001, UIE_RESP_OKAY);
    bus_write(UIE_OFS_SET, 32'h00000000, UIE_RESP_OKAY);
    check_lines(32'h00100001, 1'b0);
    // event while masked: status sticks, no interrupt
    @(posedge clk);
    eventPulse <= uie_events_t'(25'h0000008);
    @(posedge clk);
    eventPulse <= '0;
    check_lines(32'h00100001, 1'b0);
    bus_read(UIE_OFS_STATUS, 32'h00000008, UIE_RESP_OKAY);
    bus_write(UIE_OFS_SET, 32'h00000008, UIE_RESP_OKAY);
    check_lines(32'h00100009, 1'b1);
    bus_write(UIE_OFS_CLEAR, 32'h00000008, UIE_RESP_OKAY);
    check_lines(32'h00100001, 1'b0);
    bus_write(UIE_OFS_SET, 32'h00000008, UIE_RESP_OKAY);
    check_lines(32'h00100009, 1'b1);
    bus_write(UIE_OFS_STATUS, 32'h00000008, UIE_RESP_OKAY);
    check_lines(32'h00100009, 1'b0);
    // isochronous OUT event with its enable already on
    @(posedge clk);
    eventPulse <= uie_events_t'(25'h0100000);
    @(posedge clk);
    eventPulse <= '0;
    check_lines(32'h00100009, 1'b1);
    // unmapped place: write ignored, read zero, both refused
    bus_write(12'h310, 32'hffffffff, UIE_RESP_SLVERR);
    bus_read(12'h310, 32'h0, UIE_RESP_SLVERR);
    bus_read(UIE_OFS_ENABLE, 32'h00100009, UIE_RESP_OKAY);
    // mid-run reset drops every enable and the pending interrupt
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    check_lines(32'h0, 1'b0);
    bus_read(UIE_OFS_SET, 32'h0, UIE_RESP_OKAY);
    final_report();
  end

endmodule

`default_nettype wire
